// ---- rtl/ssof_framer.sv ----
/*
 * Output stage of a sonic anemometer: sample buffer, prompted answers,
 * decimated ASCII records with counter and signature, Wishbone registers.
 * Assumes sample and prompt inputs come from logic on sys_clk.
 */
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssof_consts.svh"

// What this block does
// - Buffer each finished sample until the next one arrives
// - Mode 0 prompt triggers, returns older sample
// - Mode 1 prompt returns newest filtered sample
// - Mode 1 only over packet bus
// - Mode 1 answer within five milliseconds
// - Free-running record rates 10/20/50/100 Hz
// - Decimate raw in mode 2, filtered mode 3
// - Seven comma fields, carriage return ends
// - Decimal record counter wraps after 255
// - Signature last, four hex characters
// - Signature covers x through counter field
// - Signature seed is 0xaaaa
// - Shift-add step per covered byte
// - Record offset within one output period
// - Modes 1-3 self-trigger at 100 Hz
// - Missing prompts fall back to 1 Hz
// - Report filter and mode output delays
module ssof_framer import ssof_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `SSOF_TICK_CYC,
    parameter int unsigned LOST_CYCLES = `SSOF_LOST_CYC,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ssof_sample_t sampleRaw,
    input wire ssof_sample_t sampleFilt,
    input wire logic sampleValid,
    output logic measTrig,
    input wire logic promptReq,
    output logic respValid,
    output ssof_sample_t respData,
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady
);
    ssof_ctrl_t ctrl_q;
    ssof_sample_t bufRaw_q, bufFilt_q, rec_q;
    ssof_ser_t ser_q;
    logic [31:0] tickCnt_q, secCnt_q, idleCnt_q;
    logic [3:0] decCnt_q, decDiv;
    logic tick, secTick, decEvent, promptOk, lost_q, cfgErr, fifoFull;
    logic [2:0] field_q;
    logic [1:0] nib_q, dig_q;
    logic [7:0] recCnt_q, sigHi_q, sigLo_q, serByte, sigSum;
    logic covered, push, fifoReady, startRec;
    logic [7:0] hund, tens, ones;
    logic [15:0] curField;
    logic [15:0] sigWord;

    function automatic logic [7:0] hexChr(input logic [3:0] n);
        hexChr = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
    endfunction

    // ======================================================================
    // Sample buffer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bufRaw_q <= '0;
            bufFilt_q <= '0;
        end else if (sampleValid) begin
            bufRaw_q <= sampleRaw;
            bufFilt_q <= sampleFilt;
        end
    end

    // ======================================================================
    // Internal timers
    always_ff @(posedge sys_clk) begin
        if (sys_rst || tick) begin
            tickCnt_q <= '0;
        end else begin
            tickCnt_q <= tickCnt_q + 32'h1;
        end
    end
    assign tick = (tickCnt_q == TICK_CYCLES - 1);

    always_ff @(posedge sys_clk) begin
        if (sys_rst || secTick) begin
            secCnt_q <= '0;
        end else begin
            secCnt_q <= secCnt_q + 32'h1;
        end
    end
    assign secTick = (secCnt_q == LOST_CYCLES - 1);

    // ======================================================================
    // Prompted answers and lost-trigger fallback
    // A sync-bus prompt in mode 1 is dropped: that bus cannot carry filtered data
    assign cfgErr = (ctrl_q.mode == MODE_PROMPT_FILT) && !ctrl_q.pktBus;
    assign promptOk = promptReq && ((ctrl_q.mode == MODE_EXT_TRIG)
        || (ctrl_q.mode == MODE_PROMPT_FILT && ctrl_q.pktBus));

    always_ff @(posedge sys_clk) begin
        if (sys_rst || promptOk || ctrl_q.mode[1]) begin
            idleCnt_q <= '0;
        end else if (idleCnt_q != LOST_CYCLES - 1) begin
            idleCnt_q <= idleCnt_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || promptOk || ctrl_q.mode[1]) begin
            lost_q <= 1'b0;
        end else if (idleCnt_q == LOST_CYCLES - 1) begin
            lost_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            respValid <= 1'b0;
            respData <= '0;
        end else begin
            respValid <= promptOk || (lost_q && secTick);
            if (ctrl_q.mode == MODE_PROMPT_FILT) begin
                respData <= bufFilt_q;
            end else begin
                respData <= bufRaw_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            measTrig <= 1'b0;
        end else if (ctrl_q.mode == MODE_EXT_TRIG) begin
            measTrig <= promptOk || (lost_q && secTick);
        end else begin
            measTrig <= tick;
        end
    end

    // ======================================================================
    // Decimation of the 100 Hz stream
    always_comb begin
        unique case (ctrl_q.rateSel)
            2'd0: decDiv = 4'd10;
            2'd1: decDiv = 4'd5;
            2'd2: decDiv = 4'd2;
            2'd3: decDiv = 4'd1;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !ctrl_q.mode[1]) begin
            decCnt_q <= '0;
        end else if (tick) begin
            decCnt_q <= decEvent ? 4'd0 : decCnt_q + 4'd1;
        end
    end
    assign decEvent = tick && ctrl_q.mode[1] && (decCnt_q >= decDiv - 4'd1);
    // A record still draining when the next is due is skipped, not queued
    assign startRec = decEvent && (ser_q == SER_IDLE);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rec_q <= '0;
        end else if (startRec) begin
            rec_q <= (ctrl_q.mode == MODE_FREE_FILT) ? bufFilt_q : bufRaw_q;
        end
    end

    // ======================================================================
    // Record serialiser
    always_comb begin
        unique case (field_q)
            3'd0: curField = rec_q.windX;
            3'd1: curField = rec_q.windY;
            3'd2: curField = rec_q.windZ;
            3'd3: curField = rec_q.sonicTemp;
            default: curField = rec_q.diagWord;
        endcase
    end

    assign hund = (recCnt_q >= 8'd200) ? 8'd2 : ((recCnt_q >= 8'd100) ? 8'd1 : 8'd0);
    assign tens = (recCnt_q - hund * 8'd100) / 8'd10;
    assign ones = recCnt_q - hund * 8'd100 - tens * 8'd10;
    assign sigWord = {sigHi_q, sigLo_q};

    always_comb begin
        unique case (ser_q)
            SER_HEX: serByte = hexChr(curField[4'd12 - {nib_q, 2'b00} +: 4]);
            SER_SEP: serByte = `SSOF_CHR_COMMA;
            SER_CNT: serByte = 8'h30 + ((dig_q == 2'd0) ? hund
                : ((dig_q == 2'd1) ? tens : ones));
            SER_SIG: serByte = hexChr(sigWord[4'd12 - {nib_q, 2'b00} +: 4]);
            SER_CR: serByte = `SSOF_CHR_CR;
            default: serByte = 8'h00;
        endcase
    end

    assign push = (ser_q != SER_IDLE) && fifoReady;
    assign covered = (ser_q == SER_HEX) || (ser_q == SER_CNT)
        || (ser_q == SER_SEP && field_q != 3'd5);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ser_q <= SER_IDLE;
            field_q <= '0;
            nib_q <= '0;
            dig_q <= '0;
        end else if (startRec) begin
            ser_q <= SER_HEX;
            field_q <= '0;
            nib_q <= '0;
        end else if (push) begin
            unique case (ser_q)
                SER_HEX, SER_SIG: begin
                    nib_q <= nib_q + 2'd1;
                    if (nib_q == 2'd3) begin
                        ser_q <= (ser_q == SER_HEX) ? SER_SEP : SER_CR;
                    end
                end
                SER_SEP: begin
                    if (field_q == 3'd5) begin
                        ser_q <= SER_SIG;
                    end else if (field_q == 3'd4) begin
                        field_q <= 3'd5;
                        ser_q <= SER_CNT;
                        // Leading zeros suppressed
                        dig_q <= (recCnt_q >= 8'd100) ? 2'd0 : ((recCnt_q >= 8'd10) ? 2'd1 : 2'd2);
                    end else begin
                        field_q <= field_q + 3'd1;
                        ser_q <= SER_HEX;
                    end
                end
                SER_CNT: begin
                    dig_q <= dig_q + 2'd1;
                    if (dig_q == 2'd2) begin
                        ser_q <= SER_SEP;
                    end
                end
                SER_CR: ser_q <= SER_IDLE;
                default: ser_q <= SER_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            recCnt_q <= `SSOF_CNT_RESET;
        end else if (push && ser_q == SER_CR) begin
            recCnt_q <= recCnt_q + 8'd1;
        end
    end

    // ======================================================================
    // Signature accumulator
    assign sigSum = {sigLo_q[6:0], 1'b0} + sigHi_q + serByte + {7'h00, sigLo_q[7]};

    always_ff @(posedge sys_clk) begin
        if (sys_rst || startRec) begin
            sigHi_q <= 8'(`SSOF_SIG_SEED >> 8);
            sigLo_q <= 8'(`SSOF_SIG_SEED);
        end else if (push && covered) begin
            sigHi_q <= sigLo_q;
            sigLo_q <= sigSum;
        end
    end

    // ======================================================================
    // Output FIFO; a stalled link holds the serialiser
    ssof_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .inData(serByte),
        .inValid(ser_q != SER_IDLE),
        .inReady(fifoReady),
        .outData(txData),
        .outValid(txValid),
        .outReady(txReady),
        .isFull(fifoFull)
    );

    // ======================================================================
    // Wishbone registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_q <= `SSOF_CTRL_RESET;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
            && wb_adr_i == `SSOF_ADR_CTRL) begin
            ctrl_q <= wb_dat_i[6:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= '0;
            unique case (wb_adr_i)
                `SSOF_ADR_CTRL: wb_dat_o[6:0] <= ctrl_q;
                `SSOF_ADR_STATUS: wb_dat_o[11:0] <= {fifoFull, ser_q != SER_IDLE,
                    cfgErr, lost_q, recCnt_q};
                `SSOF_ADR_DELAY: begin
                    if (ctrl_q.mode == MODE_FREE_RAW) begin
                        wb_dat_o[9:0] <= 10'(`SSOF_DLY_UNF_MS);
                    end else if (ctrl_q.mode != MODE_EXT_TRIG) begin
                        wb_dat_o[9:0] <= (ctrl_q.bandSel == 2'd0) ? 10'(`SSOF_DLY_BW5_MS)
                            : ((ctrl_q.bandSel == 2'd1) ? 10'(`SSOF_DLY_BW10_MS)
                            : 10'(`SSOF_DLY_BW25_MS));
                    end
                end
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // ======================================================================
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_BUF_HOLD: assert property (
        sampleValid ##1 !sampleValid |-> bufRaw_q == $past(sampleRaw))
        else $error("buffer lost its sample");
    AST_M0_PROMPT: assert property (
        promptReq && ctrl_q.mode == MODE_EXT_TRIG |=> measTrig && respValid
            && respData == $past(bufRaw_q))
        else $error("mode 0 prompt answered wrongly");
    AST_M1_FILT: assert property (
        promptOk && ctrl_q.mode == MODE_PROMPT_FILT |=> respData == $past(bufFilt_q))
        else $error("mode 1 answer not filtered sample");
    AST_M1_BUS: assert property (
        promptReq && cfgErr && !lost_q |=> !respValid)
        else $error("mode 1 prompt on sync bus answered");
    AST_TICK_TRIG: assert property (
        tick && ctrl_q.mode != MODE_EXT_TRIG && $stable(ctrl_q) |=> measTrig)
        else $error("self trigger missed");
    AST_REC_START: assert property (
        startRec |=> ser_q == SER_HEX && rec_q == $past(ctrl_q.mode == MODE_FREE_FILT
            ? bufFilt_q : bufRaw_q))
        else $error("record not started with right sample");
    AST_CNT_WRAP: assert property (
        push && ser_q == SER_CR && recCnt_q == 8'hff |=> recCnt_q == 8'h00 && ser_q == SER_IDLE)
        else $error("record counter did not wrap");
    AST_SEED: assert property (
        startRec |=> {sigHi_q, sigLo_q} == `SSOF_SIG_SEED)
        else $error("signature not reseeded");
    AST_SIG_FROZEN: assert property (
        ser_q == SER_SIG |-> $stable({sigHi_q, sigLo_q}))
        else $error("signature moved after counter");

    COV_RECORD: cover property (push && ser_q == SER_CR);
    COV_LOST: cover property (lost_q && respValid);
    COV_STALL: cover property (ser_q != SER_IDLE && !fifoReady);
endmodule

`default_nettype wire

// ---- rtl/ssof_consts.svh ----
/*
 * Constants of the sample output framer: register offsets, field positions,
 * reset values, timing figures and record characters.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef SSOF_CONSTS_SVH
`define SSOF_CONSTS_SVH

// ==========================================================================
// Register map (byte addresses, 32-bit aligned words)
`define SSOF_ADR_CTRL 8'h00
`define SSOF_ADR_STATUS 8'h04
`define SSOF_ADR_DELAY 8'h08

// ==========================================================================
// Control field positions and reset value
`define SSOF_CTRL_MODE_LSB 0
`define SSOF_CTRL_RATE_LSB 2
`define SSOF_CTRL_BW_LSB 4
`define SSOF_CTRL_PKTBUS_BIT 6
`define SSOF_CTRL_RESET 7'h00

// ==========================================================================
// Status field positions
`define SSOF_STAT_CNT_LSB 0
`define SSOF_STAT_LOST_BIT 8
`define SSOF_STAT_CFGERR_BIT 9
`define SSOF_STAT_BUSY_BIT 10
`define SSOF_STAT_FULL_BIT 11

// ==========================================================================
// Timing
`define SSOF_CLK_HZ 20000000
`define SSOF_TICK_HZ 100
`define SSOF_LOST_HZ 1
`define SSOF_TICK_CYC (`SSOF_CLK_HZ / `SSOF_TICK_HZ)
`define SSOF_LOST_CYC (`SSOF_CLK_HZ / `SSOF_LOST_HZ)
`define SSOF_DLY_UNF_MS 10
`define SSOF_DLY_BW5_MS 795
`define SSOF_DLY_BW10_MS 395
`define SSOF_DLY_BW25_MS 155

// ==========================================================================
// Record characters and signature seed
`define SSOF_SIG_SEED 16'haaaa
`define SSOF_CHR_COMMA 8'h2c
`define SSOF_CHR_CR 8'h0d
`define SSOF_CNT_RESET 8'h00

`endif

// ---- rtl/ssof_pkg.sv ----
/*
 * Types of the sample output framer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ssof_pkg;

    // ======================================================================
    // Operating modes and serialiser states
    typedef enum logic [1:0] {
        MODE_EXT_TRIG,
        MODE_PROMPT_FILT,
        MODE_FREE_RAW,
        MODE_FREE_FILT
    } ssof_mode_t;

    typedef enum logic [2:0] {
        SER_IDLE,
        SER_HEX,
        SER_SEP,
        SER_CNT,
        SER_SIG,
        SER_CR
    } ssof_ser_t;

    // ======================================================================
    // One measurement: three wind axes, sonic temperature, diagnostic word
    typedef struct packed {
        logic [15:0] windX;
        logic [15:0] windY;
        logic [15:0] windZ;
        logic [15:0] sonicTemp;
        logic [15:0] diagWord;
    } ssof_sample_t;

    typedef struct packed {
        logic pktBus;
        logic [1:0] bandSel;
        logic [1:0] rateSel;
        ssof_mode_t mode;
    } ssof_ctrl_t;

endpackage

// ---- rtl/ssof_fifo.sv ----
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/1ps
`default_nettype none

module ssof_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    output logic isFull
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    logic empty;

    assign empty = (wrPtr_q == rdPtr_q);
    assign isFull = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    assign inReady = !isFull;
    assign outValid = !empty;
    assign outData = mem[rdPtr_q[AW-1:0]];

    // ======================================================================
    // Storage and pointers
    always_ff @(posedge sys_clk) begin
        if (inValid && !isFull) begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
        end else if (inValid && !isFull) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdPtr_q <= '0;
        end else if (outReady && !empty) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
endmodule

`default_nettype wire

// ---- tb/ssof_host_model.sv ----
/*
 * Host-side receiver of framer records: takes bytes with random stalls and
 * hands each finished line to the bench.
 * Assumes the framer's clock and a byte taken on valid and ready together.
 */
`timescale 1ns/1ps
`default_nettype none

module ssof_host_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady = 1'b0,
    input wire logic holdOff,
    output logic [319:0] lineBits = '0,
    output logic lineDone = 1'b0
);
    integer hostSeed = 32'h1f3c5a07;
    logic fresh = 1'b1;

    // ==========================================================================
    // Byte intake; a long hold lets the FIFO fill and the serialiser wait
    always @(posedge sys_clk) begin
        lineDone <= 1'b0;
        if (sys_rst) begin
            txReady <= 1'b0;
            fresh <= 1'b1;
        end else begin
            txReady <= !holdOff && (($random(hostSeed) & 3) != 0);
            if (txValid === 1'b1 && txReady) begin
                lineBits <= fresh ? {312'h0, txData} : {lineBits[311:0], txData};
                fresh <= (txData == 8'h0d);
                lineDone <= (txData == 8'h0d);
            end
        end
    end
endmodule

`default_nettype wire

// ---- tb/ssof_framer_tb.sv ----
/*
 * Self-checking bench of the sample output framer: registers, prompts,
 * lost trigger, free-running records through a stalling host.
 * Assumes shortened tick and lost-trigger counts set below.
 */
`timescale 1ns/1ps
`default_nettype none

module ssof_framer_tb import ssof_pkg::*; ();
    localparam int TICK = 60;
    localparam int LOST = 2000;
    localparam logic [41:0] CTRL_SEQ = {7'h41, 7'h51, 7'h61, 7'h71, 7'h02, 7'h00};
    localparam logic [59:0] DLY_SEQ = {10'd795, 10'd395, 10'd155, 10'd155, 10'd10, 10'd0};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, measTrig, respValid;
    logic [7:0] wbAdr = 8'h00, txData;
    logic [31:0] wbDatW = 32'h0, wbDatR, rd;
    ssof_sample_t sampleRaw = '0, sampleFilt = '0, respData, recSample = '0;
    logic sampleValid = 1'b0, promptReq = 1'b0, holdOff = 1'b0, chkTrig = 1'b0;
    logic txValid, txReady, lineDone;
    logic [319:0] lineBits, expLine;
    logic [7:0] expCnt = 8'h00;
    integer seed = 32'h80b153de;
    int num_errors = 0, samples_checked = 0, lineCount = 0, trigCount = 0, t0;
    time lastLine = 0, spacing = 0;
    ssof_sample_t respQ[$];

    ssof_framer #(.TICK_CYCLES(TICK), .LOST_CYCLES(LOST), .FIFO_DEPTH(32)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .sampleRaw(sampleRaw),
        .sampleFilt(sampleFilt), .sampleValid(sampleValid), .measTrig(measTrig),
        .promptReq(promptReq), .respValid(respValid), .respData(respData),
        .txData(txData), .txValid(txValid), .txReady(txReady));
    ssof_host_model host_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .txData(txData),
        .txValid(txValid), .txReady(txReady), .holdOff(holdOff),
        .lineBits(lineBits), .lineDone(lineDone));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // ==========================================================================
    // Reporting
    task automatic check(input string what, input logic [319:0] exp,
                         input logic [319:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d errors", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic waitFor(input string what, input int lim);
        check({"wait for ", what}, 1'b1, lim > 0);
        if (lim <= 0) report_and_stop();
    endtask

    // ==========================================================================
    // Drivers; every change lands just after a rising edge
    task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wbAck !== 1'b1 && k < 20);
        waitFor("ack", 20 - k + (wbAck === 1'b1));
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic loadSample(input logic same);
        logic [95:0] r;
        logic [95:0] f;
        r = {$random(seed), $random(seed), $random(seed)};
        f = same ? r : {$random(seed), $random(seed), $random(seed)};
        sampleRaw <= r[79:0];
        sampleFilt <= f[79:0];
        sampleValid <= 1'b1;
        @(posedge sys_clk);
        sampleValid <= 1'b0;
    endtask

    // Back-to-back prompts; each answer is noted before the request goes out
    task automatic prompt(input int cnt, input logic filt, input logic note);
        for (int i = 0; i < cnt; i++) begin
            if (note) respQ.push_back(filt ? sampleFilt : sampleRaw);
        end
        promptReq <= 1'b1;
        repeat (cnt) @(posedge sys_clk);
        promptReq <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    function automatic logic [15:0] sigOf(input string s);
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] b;
        hi = 8'haa;
        lo = 8'haa;
        for (int i = 0; i < s.len(); i++) begin
            b = (lo << 1) + hi + s[i];
            if (lo[7]) b++;
            hi = lo;
            lo = b;
        end
        return {hi, lo};
    endfunction

    function automatic logic [319:0] lineOf(input ssof_sample_t s, input logic [7:0] c);
        string t;
        logic [319:0] v;
        t = $sformatf("%h,%h,%h,%h,%h,%0d", s.windX, s.windY, s.windZ,
                      s.sonicTemp, s.diagWord, c);
        t = {t, ",", $sformatf("%h", sigOf(t)), "\015"};
        v = '0;
        for (int i = 0; i < t.len(); i++) begin
            v = {v[311:0], t[i]};
        end
        return v;
    endfunction

    // ==========================================================================
    // Output watcher: oldest note against each answer, expected line against each record
    always @(posedge sys_clk) begin
        if (!sys_rst && measTrig === 1'b1) trigCount++;
        if (!sys_rst && respValid === 1'b1) begin
            if (respQ.size() == 0) begin
                check("spare answer", 1'b0, 1'b1);
            end else begin
                check("respData", respQ.pop_front(), respData);
                if (chkTrig) check("measTrig", 1'b1, measTrig);
            end
        end
        if (!sys_rst && lineDone === 1'b1) begin
            expLine = lineOf(recSample, expCnt);
            check("record", expLine, lineBits);
            check("signature", expLine[39:8], lineBits[39:8]);
            expCnt++;
            lineCount++;
            spacing = $time - lastLine;
            lastLine = $time;
        end
    end

    // ==========================================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wbx(1'b0, 8'h00, 32'h0);
        check("ctrl", 32'h0, rd);
        wbx(1'b0, 8'h04, 32'h0);
        check("status", 32'h0, rd);
        wbx(1'b1, 8'h10, 32'hffffffff);
        wbx(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'h0, rd);
        chkTrig = 1'b1;
        for (int i = 1; i <= 3; i++) begin
            loadSample(1'b0);
            prompt(i, 1'b0, 1'b1);
        end
        chkTrig = 1'b0;
        wbx(1'b1, 8'h00, 32'h01);
        prompt(1, 1'b1, 1'b0);
        wbx(1'b0, 8'h04, 32'h0);
        check("sync bus error", 1'b1, rd[9]);
        wbx(1'b1, 8'h00, 32'h41);
        loadSample(1'b0);
        prompt(2, 1'b1, 1'b1);
        recSample = sampleRaw;
        for (int i = 0; i < 6; i++) begin
            wbx(1'b1, 8'h00, {25'h0, CTRL_SEQ[41 - 7 * i -: 7]});
            wbx(1'b0, 8'h08, 32'h0);
            check("delay", DLY_SEQ[59 - 10 * i -: 10], rd[9:0]);
        end
        chkTrig = 1'b1;
        respQ.push_back(sampleRaw);
        t0 = 2 * LOST + 200;
        while (respQ.size() != 0 && t0 > 0) begin
            @(posedge sys_clk);
            t0--;
        end
        waitFor("lost trigger", t0);
        wbx(1'b0, 8'h04, 32'h0);
        check("lost flag", 1'b1, rd[8]);
        prompt(1, 1'b0, 1'b1);
        wbx(1'b0, 8'h04, 32'h0);
        check("lost flag", 1'b0, rd[8]);
        loadSample(1'b1);
        recSample = sampleFilt;
        wbx(1'b1, 8'h00, 32'h03);
        t0 = 40 * TICK;
        while (lineCount < 3 && t0 > 0) begin
            @(posedge sys_clk);
            t0--;
        end
        waitFor("slow records", t0);
        check("spacing", 1'b1, spacing > 540 * 50 && spacing < 660 * 50);
        wbx(1'b1, 8'h00, 32'h0e);
        @(negedge sys_clk);
        t0 = trigCount;
        repeat (10 * TICK) @(negedge sys_clk);
        check("ticks", 32'd10, trigCount - t0);
        @(posedge sys_clk);
        holdOff <= 1'b1;
        repeat (150) @(posedge sys_clk);
        wbx(1'b0, 8'h04, 32'h0);
        check("full and busy", 2'b11, rd[11:10]);
        holdOff <= 1'b0;
        t0 = 30000;
        while (lineCount < 262 && t0 > 0) begin
            @(posedge sys_clk);
            t0--;
        end
        waitFor("fast records", t0);
        report_and_stop();
    end
endmodule

`default_nettype wire
